// [wdrs_pkg.sv]
/*
  package for the watchdog and regulator standby block: register map,
  field positions, reset values and timing counts.
  assumes a 100 MHz system clock and a 32-bit apb register bus.
*/
`default_nettype none

package wdrs_pkg;

  // ****************************************************************
  // bus offsets (byte addresses)
  // ****************************************************************
  localparam logic [11:0] WDRS_OFF_CONFIG = 12'h000;
  localparam logic [11:0] WDRS_OFF_CTRL   = 12'h004;
  localparam logic [11:0] WDRS_OFF_RSTCTL = 12'h008;
  localparam logic [11:0] WDRS_OFF_STATUS = 12'h00C;
  localparam logic [11:0] WDRS_OFF_MASK   = 12'h010;
  localparam logic [11:0] WDRS_OFF_COUNT  = 12'h014;

  // ****************************************************************
  // config word fields
  // ****************************************************************
  localparam int WDRS_CFG_PS_LSB = 0;
  localparam int WDRS_CFG_PSA    = 4;
  localparam int WDRS_CFG_EN     = 5;

  // ****************************************************************
  // control register: write-one command strobes
  // ****************************************************************
  localparam int WDRS_CTL_CLEAR = 0;
  localparam int WDRS_CTL_SLEEP = 1;
  localparam int WDRS_CTL_IDLE  = 2;
  localparam int WDRS_CTL_SWCLK = 3;

  // ****************************************************************
  // reset control register fields
  // ****************************************************************
  localparam int WDRS_RC_BROWN = 1;
  localparam int WDRS_RC_IDLE  = 2;
  localparam int WDRS_RC_SLEEP = 3;
  localparam int WDRS_RC_TMO   = 4;
  localparam int WDRS_RC_STBY  = 8;

  // ****************************************************************
  // interrupt status bits
  // ****************************************************************
  localparam int WDRS_IRQ_WAKE = 0;
  localparam int WDRS_IRQ_RST  = 1;
  localparam int WDRS_IRQ_BROWN = 2;
  localparam int WDRS_IRQ_W    = 3;

  // ****************************************************************
  // reset values
  // ****************************************************************
  localparam logic [31:0] WDRS_CONFIG_RST = 32'h0000_002F;
  localparam logic [31:0] WDRS_ZERO       = 32'h0000_0000;

  // ****************************************************************
  // timing
  // ****************************************************************
  localparam int WDRS_CLK_HZ        = 100_000_000;
  localparam int WDRS_SLOWOSC_HZ    = 31_000;
  localparam int WDRS_SLOWOSC_CYC   = WDRS_CLK_HZ / WDRS_SLOWOSC_HZ;
  localparam int WDRS_PRE_SHORT     = 32;
  localparam int WDRS_PRE_LONG      = 128;
  localparam int WDRS_REGSTART_NS   = 10_000;
  localparam int WDRS_CLK_NS        = 10;
  localparam int WDRS_REGSTART_CYC  = (WDRS_REGSTART_NS + WDRS_CLK_NS - 1) / WDRS_CLK_NS;

  typedef enum logic [1:0] {
    WDRS_RUN,
    WDRS_SLEEP,
    WDRS_IDLE,
    WDRS_WAKE
  } wdrs_mode_e;

endpackage

`default_nettype wire

// [wdrs_top.sv]
/*
  watchdog timer with brown-out capture and regulator standby control,
  reached over apb.
  assumes a 100 MHz clock, a synchronous active-high reset, and that the
  surrounding core reports clock-switch completion and brown-out as pulses.
*/
// Notes on behaviour
// - watchdog ticks from the low-power rc oscillator, enabled with the watchdog
// - prescaler divides by 32 or 128, chosen by a configuration bit
// - base timeout about 1 ms or 4 ms at 31 kHz
// - postscaler divides by one of 16 ratios, 1:1 to 1:32768
// - any device reset clears counter, prescaler and postscaler
// - completed clock switch clears counter, prescaler and postscaler
// - entering sleep or idle clears counter, prescaler and postscaler
// - leaving sleep or idle clears counter, prescaler and postscaler
// - clear instruction clears counter, prescaler and postscaler
// - enabled watchdog keeps counting in sleep and idle
// - timeout in sleep or idle wakes the core instead of resetting
// - timeout flag is sticky; only software clears it
// - brown-out with regulator enabled raises reset and sets brown-out flag
// - standby bit clear: regulator off and flash unpowered in sleep
// - waking from regulator standby waits the regulator start-up interval
// - standby bit set: flash stays powered, wake without start-up wait
// - start-up interval about 10 us, execution held throughout
`timescale 1ns/1ps
`default_nettype none

module wdrs_top
  import wdrs_pkg::*;
#(
  parameter int SLOWOSC_CYC  = WDRS_SLOWOSC_CYC,
  parameter int REGSTART_CYC = WDRS_REGSTART_CYC
) (
  input  wire logic        clk_i,
  input  wire logic        reset_i,
  input  wire logic        psel_i,
  input  wire logic        penable_i,
  input  wire logic        pwrite_i,
  input  wire logic [11:0] paddr_i,
  input  wire logic [31:0] pwdata_i,
  input  wire logic [3:0]  pstrb_i,
  output logic      [31:0] prdata_o,
  output logic             pready_o,
  output logic             pslverr_o,
  input  wire logic        regulator_en_i,
  input  wire logic        brownout_i,
  input  wire logic        clk_switch_done_i,
  input  wire logic        wake_event_i,
  output logic             device_reset_o,
  output logic             core_run_o,
  output logic             low_power_rc_osc_en_o,
  output logic             flash_power_o,
  output logic             regulator_on_o,
  output logic             irq_o
);

  // ****************************************************************
  // registers and state
  // ****************************************************************
  logic [5:0]            config_word_one_r;
  logic [WDRS_IRQ_W-1:0] status_r;
  logic [WDRS_IRQ_W-1:0] mask_r;
  logic                  brownout_reset_flag_r;
  logic                  wdog_timeout_flag_r;
  logic                  sleep_flag_r;
  logic                  idle_flag_r;
  logic                  regulator_standby_control_r;
  wdrs_mode_e            mode_r;
  logic [15:0]           osc_div_r;
  logic [6:0]            prescale_r;
  logic [14:0]           watchdog_counter_r;
  logic [15:0]           regstart_r;
  logic                  rst_req_r;

  logic       wr_en;
  logic       rd_en;
  logic       wdog_en;
  logic       osc_tick;
  logic       pre_tick;
  logic       timeout;
  logic       wdog_clear_instr;
  logic       power_save_sleep;
  logic       power_save_idle;
  logic       wdog_wipe;
  logic       wake;
  logic       in_low_power;
  logic [3:0] wdog_postscale_select;

  function automatic logic [14:0] post_limit(input logic [3:0] sel);
    post_limit = 15'((32'd1 << sel) - 32'd1);
  endfunction

  function automatic logic wr_hit(input logic [11:0] off);
    wr_hit = wr_en && (paddr_i == off) && pstrb_i[0];
  endfunction

  // ****************************************************************
  // apb decode
  // ****************************************************************
  assign wr_en = psel_i && penable_i && pwrite_i && pready_o;
  assign rd_en = psel_i && !penable_i && !pwrite_i;

  assign wdog_en               = config_word_one_r[WDRS_CFG_EN];
  assign wdog_postscale_select = config_word_one_r[3:0];
  assign in_low_power          = (mode_r == WDRS_SLEEP) || (mode_r == WDRS_IDLE);
  assign wdog_clear_instr      = wr_hit(WDRS_OFF_CTRL) && pwdata_i[WDRS_CTL_CLEAR]
                                 && (mode_r == WDRS_RUN);
  assign power_save_sleep      = wr_hit(WDRS_OFF_CTRL) && pwdata_i[WDRS_CTL_SLEEP]
                                 && (mode_r == WDRS_RUN);
  assign power_save_idle       = wr_hit(WDRS_OFF_CTRL) && pwdata_i[WDRS_CTL_IDLE]
                                 && (mode_r == WDRS_RUN) && !power_save_sleep;

  // ****************************************************************
  // watchdog clock and counters
  // ****************************************************************
  assign osc_tick  = wdog_en && (osc_div_r == 16'(SLOWOSC_CYC - 1));
  assign pre_tick  = osc_tick && (prescale_r == (config_word_one_r[WDRS_CFG_PSA]
                     ? 7'(WDRS_PRE_LONG - 1) : 7'(WDRS_PRE_SHORT - 1)));
  assign timeout   = pre_tick && (watchdog_counter_r == post_limit(wdog_postscale_select));
  assign wake      = in_low_power && (timeout || wake_event_i);
  assign wdog_wipe = clk_switch_done_i
                     || power_save_sleep || power_save_idle
                     || (mode_r == WDRS_WAKE && regstart_r == 16'd0)
                     || wdog_clear_instr
                     || timeout || rst_req_r;

  always_ff @(posedge clk_i) begin
    if (reset_i || wdog_wipe || !wdog_en) begin
      osc_div_r <= 16'd0;
    end else if (osc_tick) begin
      osc_div_r <= 16'd0;
    end else begin
      osc_div_r <= osc_div_r + 16'd1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (reset_i || wdog_wipe) begin
      prescale_r <= 7'd0;
    end else if (pre_tick) begin
      prescale_r <= 7'd0;
    end else if (osc_tick) begin
      prescale_r <= prescale_r + 7'd1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (reset_i || wdog_wipe) begin
      watchdog_counter_r <= 15'd0;
    end else if (pre_tick) begin
      watchdog_counter_r <= watchdog_counter_r + 15'd1;
    end
  end

  // ****************************************************************
  // power mode sequencing
  // ****************************************************************
  always_ff @(posedge clk_i) begin
    if (reset_i || rst_req_r) begin
      mode_r     <= WDRS_RUN;
      regstart_r <= 16'd0;
    end else begin
      unique case (mode_r)
        WDRS_RUN: begin
          if (power_save_sleep) begin
            mode_r <= WDRS_SLEEP;
          end else if (power_save_idle) begin
            mode_r <= WDRS_IDLE;
          end
        end
        WDRS_SLEEP: begin
          if (wake) begin
            mode_r     <= WDRS_WAKE;
            regstart_r <= (regulator_en_i && !regulator_standby_control_r)
                          ? 16'(REGSTART_CYC - 1) : 16'd0;
          end
        end
        WDRS_IDLE: begin
          if (wake) begin
            mode_r     <= WDRS_WAKE;
            regstart_r <= 16'd0;
          end
        end
        WDRS_WAKE: begin
          if (regstart_r == 16'd0) begin
            mode_r <= WDRS_RUN;
          end else begin
            regstart_r <= regstart_r - 16'd1;
          end
        end
      endcase
    end
  end

  // ****************************************************************
  // reset requests
  // ****************************************************************
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      rst_req_r <= 1'b0;
    end else begin
      rst_req_r <= (timeout && mode_r == WDRS_RUN)
                   || (brownout_i && regulator_en_i);
    end
  end

  // ****************************************************************
  // software registers
  // ****************************************************************
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      config_word_one_r           <= WDRS_CONFIG_RST[5:0];
      mask_r                      <= WDRS_ZERO[WDRS_IRQ_W-1:0];
      regulator_standby_control_r <= 1'b0;
    end else begin
      if (wr_hit(WDRS_OFF_CONFIG)) begin
        config_word_one_r <= pwdata_i[5:0];
      end
      if (wr_hit(WDRS_OFF_MASK)) begin
        mask_r <= pwdata_i[WDRS_IRQ_W-1:0];
      end
      if (wr_en && paddr_i == WDRS_OFF_RSTCTL && pstrb_i[1]) begin
        regulator_standby_control_r <= pwdata_i[WDRS_RC_STBY];
      end
    end
  end

  // hardware set wins over software write-zero
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      wdog_timeout_flag_r   <= 1'b0;
      brownout_reset_flag_r <= 1'b0;
      sleep_flag_r          <= 1'b0;
      idle_flag_r           <= 1'b0;
    end else begin
      if (timeout) begin
        wdog_timeout_flag_r <= 1'b1;
      end else if (wr_hit(WDRS_OFF_RSTCTL) && !pwdata_i[WDRS_RC_TMO]) begin
        wdog_timeout_flag_r <= 1'b0;
      end
      if (brownout_i && regulator_en_i) begin
        brownout_reset_flag_r <= 1'b1;
      end else if (wr_hit(WDRS_OFF_RSTCTL) && !pwdata_i[WDRS_RC_BROWN]) begin
        brownout_reset_flag_r <= 1'b0;
      end
      if (power_save_sleep) begin
        sleep_flag_r <= 1'b1;
      end else if (wr_hit(WDRS_OFF_RSTCTL) && !pwdata_i[WDRS_RC_SLEEP]) begin
        sleep_flag_r <= 1'b0;
      end
      if (power_save_idle) begin
        idle_flag_r <= 1'b1;
      end else if (wr_hit(WDRS_OFF_RSTCTL) && !pwdata_i[WDRS_RC_IDLE]) begin
        idle_flag_r <= 1'b0;
      end
    end
  end

  // ****************************************************************
  // interrupt status, write one to clear, set wins
  // ****************************************************************
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      status_r <= WDRS_ZERO[WDRS_IRQ_W-1:0];
      irq_o    <= 1'b0;
    end else begin
      status_r <= (status_r & ~(wr_hit(WDRS_OFF_STATUS) ? pwdata_i[WDRS_IRQ_W-1:0]
                                                        : {WDRS_IRQ_W{1'b0}}))
                  | {brownout_i && regulator_en_i,
                     timeout && mode_r == WDRS_RUN,
                     timeout && in_low_power};
      irq_o    <= |(status_r & mask_r);
    end
  end

  // ****************************************************************
  // apb answer: one wait-free access, registered read data
  // ****************************************************************
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      prdata_o  <= WDRS_ZERO;
      pready_o  <= 1'b0;
      pslverr_o <= 1'b0;
    end else begin
      pready_o  <= psel_i && !penable_i;
      pslverr_o <= psel_i && !penable_i && !(paddr_i inside {WDRS_OFF_CONFIG,
                   WDRS_OFF_CTRL, WDRS_OFF_RSTCTL, WDRS_OFF_STATUS, WDRS_OFF_MASK,
                   WDRS_OFF_COUNT});
      if (rd_en) begin
        unique case (paddr_i)
          WDRS_OFF_CONFIG: prdata_o <= {26'd0, config_word_one_r};
          WDRS_OFF_RSTCTL: prdata_o <= {23'd0, regulator_standby_control_r, 3'd0,
                                        wdog_timeout_flag_r, sleep_flag_r, idle_flag_r,
                                        brownout_reset_flag_r, 1'b0};
          WDRS_OFF_STATUS: prdata_o <= {29'd0, status_r};
          WDRS_OFF_MASK:   prdata_o <= {29'd0, mask_r};
          WDRS_OFF_COUNT:  prdata_o <= {17'd0, watchdog_counter_r};
          default:         prdata_o <= WDRS_ZERO;
        endcase
      end
    end
  end

  // ****************************************************************
  // power and reset outputs
  // ****************************************************************
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      device_reset_o        <= 1'b0;
      core_run_o            <= 1'b1;
      low_power_rc_osc_en_o <= 1'b0;
      flash_power_o         <= 1'b1;
      regulator_on_o        <= 1'b1;
    end else begin
      device_reset_o        <= rst_req_r;
      core_run_o            <= (mode_r == WDRS_RUN) && !rst_req_r;
      low_power_rc_osc_en_o <= wdog_en;
      flash_power_o         <= !(mode_r == WDRS_SLEEP && !regulator_standby_control_r);
      regulator_on_o        <= regulator_en_i
                               && !(mode_r == WDRS_SLEEP && !regulator_standby_control_r);
    end
  end

endmodule

`default_nettype wire

// [wdrs_top_sva.sv]
/*
  port checker for wdrs_top: apb handshake, reset pulse, regulator and wake.
  assumes one clock domain and the synchronous active-high reset_i.
*/
`timescale 1ns/1ps
`default_nettype none

module wdrs_top_sva
  import wdrs_pkg::*;
(
  input wire logic        clk_i,
  input wire logic        reset_i,
  input wire logic        psel_i,
  input wire logic        penable_i,
  input wire logic        pready_o,
  input wire logic        pslverr_o,
  input wire logic        regulator_en_i,
  input wire logic        brownout_i,
  input wire logic        device_reset_o,
  input wire logic        core_run_o,
  input wire logic        flash_power_o,
  input wire logic        regulator_on_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (reset_i);

  // ****************************************************************
  // properties
  // ****************************************************************
  sequence s_setup;
    psel_i && !penable_i;
  endsequence

  a_ready_after_setup: assert property (s_setup |=> pready_o)
    else $error("pready missing after setup");
  a_ready_one_cycle: assert property (pready_o |=> !pready_o)
    else $error("pready longer than one cycle");
  a_err_with_ready: assert property (pslverr_o |-> pready_o)
    else $error("pslverr without pready");
  a_reset_one_pulse: assert property (device_reset_o |=> !device_reset_o)
    else $error("device reset longer than one cycle");
  a_reset_outputs: assert property ($fell(reset_i) |-> core_run_o && flash_power_o && !device_reset_o)
    else $error("outputs wrong after reset");
  a_brownout_reset: assert property (regulator_en_i && brownout_i |-> ##[1:3] device_reset_o)
    else $error("brown-out gave no reset");
  a_wake_flash_up: assert property ($rose(core_run_o) |-> $past(flash_power_o, 3))
    else $error("core resumed before flash powered");
  a_regulator_follow: assert property (!regulator_en_i |=> !regulator_on_o)
    else $error("regulator on while disabled");
  a_flash_off_halt: assert property (!flash_power_o |-> !core_run_o)
    else $error("core runs with flash unpowered");
endmodule

bind wdrs_top wdrs_top_sva chk_u (
  .clk_i          (clk_i),
  .reset_i        (reset_i),
  .psel_i         (psel_i),
  .penable_i      (penable_i),
  .pready_o       (pready_o),
  .pslverr_o      (pslverr_o),
  .regulator_en_i (regulator_en_i),
  .brownout_i     (brownout_i),
  .device_reset_o (device_reset_o),
  .core_run_o     (core_run_o),
  .flash_power_o  (flash_power_o),
  .regulator_on_o (regulator_on_o)
);

`default_nettype wire

// [tb_wdrs_top.sv]
/*
  self-checking testbench for wdrs_top, apb master in the bench.
  assumes short counts: slow-oscillator tick every 4 clocks, start-up wait 40 clocks.
*/
`timescale 1ns/1ps
`default_nettype none

module tb_wdrs_top;
  import wdrs_pkg::*;
  localparam int LP = 4;
  localparam int TV = 40;
  logic        clk_i, reset_i, psel, penable, pwrite, reg_en, brown, swdone, wake;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic        pready, pslverr, dev_rst, run, osc_en, flash, reg_on, irq;
  int          failures, total_checks, rst_cnt;

  wdrs_top #(.SLOWOSC_CYC(LP), .REGSTART_CYC(TV)) dut_u (
    .clk_i(clk_i), .reset_i(reset_i), .psel_i(psel), .penable_i(penable),
    .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .pstrb_i(4'hF),
    .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr),
    .regulator_en_i(reg_en), .brownout_i(brown), .clk_switch_done_i(swdone),
    .wake_event_i(wake), .device_reset_o(dev_rst), .core_run_o(run),
    .low_power_rc_osc_en_o(osc_en), .flash_power_o(flash), .regulator_on_o(reg_on),
    .irq_o(irq));

  // ****************************************************************
  // clock, reset pulse counter, watchdog
  // ****************************************************************
  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end
  always @(negedge clk_i) if (dev_rst === 1'b1) rst_cnt++;
  initial begin
    #400_000;
    failures++;
    finish_test();
  end

  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] q, output logic e);
    @(posedge clk_i);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge clk_i);
    penable <= 1'b1;
    q = 32'h0000_0000;
    e = 1'b1;
    for (int n = 0; n < 20; n++) begin
      @(posedge clk_i);
      if (pready === 1'b1) begin
        q = prdata;
        e = pslverr;
        break;
      end
    end
    if (pready !== 1'b1) failures++;
    psel <= 1'b0; penable <= 1'b0;
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] q; logic e;
    apb(1'b1, a, d, q, e);
  endtask

  task automatic rd(input string nm, input logic [11:0] a, input logic [31:0] exp);
    logic [31:0] q; logic e;
    apb(1'b0, a, 32'h0000_0000, q, e);
    check(nm, q, exp);
  endtask

  // cycles until device reset (sel 0) or core running (sel 1)
  task automatic wait_for(input int sel, output int n);
    for (n = 0; n < 3000; n++) begin
      @(negedge clk_i);
      if ((sel == 0 ? dev_rst : run) === 1'b1) break;
    end
  endtask

  task automatic near(input string nm, input int n, input int exp);
    check(nm, {31'b0, (n >= exp - 8) && (n <= exp + 8)}, 32'h0000_0001);
  endtask

  task automatic pulse(input int which);
    @(posedge clk_i);
    if (which == 0) swdone <= 1'b1; else if (which == 1) brown <= 1'b1; else wake <= 1'b1;
    @(posedge clk_i);
    swdone <= 1'b0; brown <= 1'b0; wake <= 1'b0;
  endtask

  // ****************************************************************
  // scenarios
  // ****************************************************************
  task automatic t_reset();
    logic [31:0] q; logic e;
    rd("config", WDRS_OFF_CONFIG, WDRS_CONFIG_RST);
    rd("rstctl", WDRS_OFF_RSTCTL, WDRS_ZERO);
    rd("status", WDRS_OFF_STATUS, WDRS_ZERO);
    rd("count", WDRS_OFF_COUNT, WDRS_ZERO);
    apb(1'b0, 12'h020, 32'h0000_0000, q, e);
    check("unmapped err", {31'b0, e}, 32'h0000_0001);
    check("osc on", {31'b0, osc_en}, 32'h0000_0001);
  endtask

  task automatic t_timeout(input logic [31:0] cfg, input int exp);
    int n;
    wr(WDRS_OFF_CONFIG, cfg);
    wr(WDRS_OFF_CTRL, 32'h0000_0001);
    wait_for(0, n);
    near("run timeout", n, exp);
    wr(WDRS_OFF_CONFIG, WDRS_ZERO);
    repeat (2) @(negedge clk_i);
    check("osc off", {31'b0, osc_en}, 32'h0000_0000);
    rd("rstctl tmo", WDRS_OFF_RSTCTL, 32'h0000_0010);
    rd("status rst", WDRS_OFF_STATUS, 32'h0000_0002);
    wr(WDRS_OFF_MASK, 32'h0000_0002);
    repeat (2) @(posedge clk_i);
    check("irq set", {31'b0, irq}, 32'h0000_0001);
    wr(WDRS_OFF_STATUS, 32'h0000_0002);
    repeat (2) @(posedge clk_i);
    check("irq clear", {31'b0, irq}, 32'h0000_0000);
    rd("rstctl sticky", WDRS_OFF_RSTCTL, 32'h0000_0010);
    wr(WDRS_OFF_RSTCTL, WDRS_ZERO);
    rd("rstctl cleared", WDRS_OFF_RSTCTL, WDRS_ZERO);
  endtask

  task automatic t_clear(input int kind);
    int r0;
    wr(WDRS_OFF_CONFIG, 32'h0000_0020);
    r0 = rst_cnt;
    repeat (6) begin
      repeat (90) @(posedge clk_i);
      if (kind == 0) wr(WDRS_OFF_CTRL, 32'h0000_0001); else pulse(0);
    end
    check("no reset", rst_cnt, r0);
    wr(WDRS_OFF_CONFIG, WDRS_ZERO);
  endtask

  task automatic t_sleep(input logic stby, input logic idle, input logic ev);
    int n, r0, tv;
    logic off;
    off = !stby && !idle;
    tv = off ? TV : 0;
    wr(WDRS_OFF_RSTCTL, {23'b0, stby, 8'b0});
    wr(WDRS_OFF_CONFIG, ev ? 32'h0000_0000 : 32'h0000_0020);
    r0 = rst_cnt;
    wr(WDRS_OFF_CTRL, idle ? 32'h0000_0004 : 32'h0000_0002);
    repeat (2) @(negedge clk_i);
    check("halted", {31'b0, run}, 32'h0000_0000);
    check("flash", {31'b0, flash}, {31'b0, !off});
    check("regulator", {31'b0, reg_on}, {31'b0, !off});
    if (ev) pulse(2);
    wait_for(1, n);
    near("wake time", n, ev ? tv + 2 : 128 + tv);
    check("no reset", rst_cnt, r0);
    if (!ev) begin
      wait_for(0, n);
      near("cleared on wake", n, 128);
      wr(WDRS_OFF_CONFIG, WDRS_ZERO);
    end
    rd("rstctl mode", WDRS_OFF_RSTCTL, {23'b0, stby, 3'b0, !ev, !idle, idle, 2'b0});
    wr(WDRS_OFF_RSTCTL, WDRS_ZERO);
    rd("rstctl clear", WDRS_OFF_RSTCTL, WDRS_ZERO);
    wr(WDRS_OFF_STATUS, 32'h0000_0007);
  endtask

  task automatic t_brown();
    int r0;
    reg_en <= 1'b0;
    r0 = rst_cnt;
    pulse(1);
    repeat (5) @(posedge clk_i);
    check("no bor", rst_cnt, r0);
    rd("rstctl none", WDRS_OFF_RSTCTL, WDRS_ZERO);
    reg_en <= 1'b1;
    pulse(1);
    repeat (5) @(posedge clk_i);
    check("bor reset", rst_cnt, r0 + 1);
    rd("rstctl brown", WDRS_OFF_RSTCTL, 32'h0000_0002);
    rd("status bor", WDRS_OFF_STATUS, 32'h0000_0004);
    wr(WDRS_OFF_MASK, 32'h0000_0004);
    repeat (2) @(posedge clk_i);
    check("irq bor", {31'b0, irq}, 32'h0000_0001);
    wr(WDRS_OFF_MASK, WDRS_ZERO);
    repeat (2) @(posedge clk_i);
    check("irq masked", {31'b0, irq}, 32'h0000_0000);
    wr(WDRS_OFF_STATUS, 32'h0000_0004);
    wr(WDRS_OFF_RSTCTL, WDRS_ZERO);
  endtask

  task automatic finish_test();
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  initial begin
    failures = 0; total_checks = 0; rst_cnt = 0;
    reset_i = 1'b1; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 12'h000;
    pwdata = 32'h0000_0000; reg_en = 1'b1; brown = 1'b0; swdone = 1'b0; wake = 1'b0;
    repeat (12) @(posedge clk_i);
    reset_i <= 1'b0;
    @(posedge clk_i);
    t_reset();
    t_timeout(32'h0000_0020, 32 * LP);
    t_timeout(32'h0000_0030, 128 * LP);
    t_timeout(32'h0000_0021, 64 * LP);
    t_clear(0);
    t_clear(1);
    t_sleep(1'b0, 1'b0, 1'b0);
    t_sleep(1'b1, 1'b0, 1'b0);
    t_sleep(1'b0, 1'b1, 1'b0);
    t_sleep(1'b0, 1'b0, 1'b1);
    t_brown();
    finish_test();
  end
endmodule

`default_nettype wire
